// File: dcab_pkg.sv
// Shared constants and types for the DMA channel align and burst engine.
// Assumes a single core clock domain and word-indexed Avalon-MM addressing.
package dcab_pkg;

  // Register word indices (byte address is four times the index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_PCI  = 3'h1;
  localparam logic [2:0] REG_SDR  = 3'h2;
  localparam logic [2:0] REG_BC   = 3'h3;
  localparam logic [2:0] REG_IBD  = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;

  // Control register field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_DIR   = 1;
  localparam int CTRL_PLEN  = 15;
  localparam int CTRL_SLEN  = 16;

  // Status register field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_CLS  = 1;
  localparam int STAT_DONE = 3;

  // Reset values
  localparam logic [15:0] IBD_RST  = 16'h0004;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  // Burst sizes in Dwords, and the all-bytes enable mask
  localparam logic [10:0] PLEN_SHORT = 11'h008;
  localparam logic [10:0] PLEN_LONG  = 11'h010;
  localparam logic [10:0] SLEN_BASE  = 11'h004;
  localparam logic [3:0]  BE_ALL     = 4'hF;

  // Alignment classes
  localparam logic [1:0] CLS_FULL  = 2'h0;
  localparam logic [1:0] CLS_DWORD = 2'h1;
  localparam logic [1:0] CLS_UNAL  = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_BURST, ST_FLUSH} dcab_fsm_t;

  // Source read request
  typedef struct packed {
    logic [31:0] addr;
    logic [10:0] len;
  } dcab_rd_t;

  // Destination write
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } dcab_wr_t;

  // Whole engine state
  typedef struct packed {
    dcab_fsm_t   fsm;
    logic        dir;
    logic        plen;
    logic [2:0]  slen;
    logic [31:0] pci_base;
    logic [31:0] sdr_base;
    logic [23:0] bc_cfg;
    logic [15:0] ibd;
    logic        done;
    logic [1:0]  cls;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [23:0] bc;
    logic [23:0] dwr;
    logic [1:0]  sh;
    logic        skip;
    logic        first_src;
    logic        first_wr;
    logic [3:0]  fbe;
    logic [3:0]  lbe;
    logic [31:0] prev;
    logic [15:0] dly;
    logic [10:0] need;
    logic [10:0] got;
    logic [10:0] raw;
    logic [1:0]  head;
    logic        rd_req;
    dcab_rd_t    rd;
    logic        stop;
    logic        wr_valid;
    dcab_wr_t    wr;
    logic        waitreq;
    logic [31:0] rdata;
  } dcab_st_t;

endpackage

// File: dcab_top.sv
// DMA channel data path: byte enables, lane rotation, packing and burst control.
// Assumes the source, destination and FIFO status signals run on clk.
`timescale 1ns/100ps
`default_nettype none
module dcab_top
  import dcab_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             rd_req,
  output dcab_rd_t         rd,
  output logic      [3:0]  rd_be,
  input  wire logic        src_valid,
  input  wire logic [31:0] src_data,
  input  wire logic        src_end,
  input  wire logic [10:0] ob_space,
  input  wire logic        ib_full,
  input  wire logic        mlt_expired,
  output logic             burst_stop,
  output logic             wr_valid,
  output dcab_wr_t         wr
);

  dcab_st_t q;           // Registered state
  dcab_st_t d;           // Next state
  logic [3:0] rd_be_q;   // Read byte enables, held fully on

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign rd_req          = q.rd_req;
  assign rd              = q.rd;
  assign burst_stop      = q.stop;
  assign wr_valid        = q.wr_valid;
  assign wr              = q.wr;
  assign rd_be           = rd_be_q;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [1:0]  slo;       // Source offset
    logic [1:0]  dlo;       // Destination offset
    logic [1:0]  nlast;     // Bytes in final write
    logic [24:0] sum25;     // Wide sums
    logic [10:0] len;       // Burst size limit
    logic [10:0] modv;      // Address position within burst
    logic [10:0] n;         // Useful Dwords this burst
    logic [10:0] idx;       // Raw word index
    logic [2:0]  bytes;     // Bytes taken from a word
    logic [63:0] win;       // Two-word window
    logic [31:0] cur;       // Word being realigned
    logic        emit;      // Produce a destination write
    logic        endb;      // Burst ends now
    logic [31:0] sa;        // Start source address
    logic [31:0] da;        // Start destination address
    slo   = 2'h0;
    dlo   = 2'h0;
    nlast = 2'h0;
    sum25 = 25'h0;
    len   = 11'h0;
    modv  = 11'h0;
    n     = 11'h0;
    idx   = 11'h0;
    bytes = 3'h0;
    win   = 64'h0;
    cur   = 32'h0;
    emit  = 1'b0;
    endb  = 1'b0;
    sa    = 32'h0;
    da    = 32'h0;
    d          = q;
    d.rd_req   = 1'b0;
    d.wr_valid = 1'b0;
    d.stop     = 1'b0;
    d.waitreq  = 1'b1;

    // Bus: one wait cycle, then the access completes
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      case (avs_address)
        REG_CTRL: d.rdata = {13'h0, q.slen, q.plen, 13'h0, q.dir, 1'b0};
        REG_PCI:  d.rdata = q.pci_base;
        REG_SDR:  d.rdata = q.sdr_base;
        REG_BC:   d.rdata = {8'h0, q.bc};
        REG_IBD:  d.rdata = {16'h0, q.ibd};
        REG_STAT: d.rdata = {28'h0, q.done, q.cls, q.fsm != ST_IDLE};
        default:  d.rdata = ZERO32;   // Unmapped reads as zero
      endcase
    end

    // Writes commit at the edge where waitrequest is seen low
    if (avs_write && !q.waitreq) begin
      case (avs_address)
        REG_STAT: begin
          // Write one clears done; a same-cycle set below wins
          if (avs_writedata[STAT_DONE]) begin
            d.done = 1'b0;
          end
        end
        default: begin
          // Configuration is frozen while the channel runs
          if (q.fsm == ST_IDLE) begin
            case (avs_address)
              REG_PCI: d.pci_base = avs_writedata;
              REG_SDR: d.sdr_base = avs_writedata;
              REG_BC:  d.bc_cfg   = avs_writedata[23:0];
              REG_IBD: d.ibd      = avs_writedata[15:0];
              REG_CTRL: begin
                d.dir  = avs_writedata[CTRL_DIR];
                d.plen = avs_writedata[CTRL_PLEN];
                d.slen = avs_writedata[CTRL_SLEN +: 3];
              end
              default: ;
            endcase
          end
        end
      endcase
    end

    case (q.fsm)
      // Start: latch geometry of the move
      ST_IDLE: begin
        if (avs_write && !q.waitreq && avs_address == REG_CTRL && avs_writedata[CTRL_START]) begin
          sa = avs_writedata[CTRL_DIR] ? q.sdr_base : q.pci_base;
          da = avs_writedata[CTRL_DIR] ? q.pci_base : q.sdr_base;
          slo = sa[1:0];
          dlo = da[1:0];
          // alignment class from low address bits
          if (q.pci_base[3:0] == q.sdr_base[3:0]) begin
            d.cls = CLS_FULL;
          end else if (q.pci_base[1:0] == q.sdr_base[1:0]) begin
            d.cls = CLS_DWORD;
          end else begin
            d.cls = CLS_UNAL;
          end
          // left rotation amount, right shown as wrap
          d.sh = dlo - slo;
          // Right shift needs two source words for first write
          d.skip = dlo < slo;
          d.fbe = BE_ALL << dlo;
          // lowest N bytes, zero means all four
          nlast = dlo + q.bc_cfg[1:0];
          d.lbe = (nlast == 2'h0) ? BE_ALL : 4'((5'h01 << nlast) - 5'h01);
          sum25 = {23'h0, dlo} + {1'b0, q.bc_cfg} + 25'h3;
          d.dwr = sum25[25-1:2] & 24'hFF_FFFF;
          d.src_addr  = sa;
          d.dst_addr  = da;
          d.bc        = q.bc_cfg;
          d.first_src = 1'b1;
          d.first_wr  = 1'b1;
          d.prev      = ZERO32;
          d.dly       = q.ibd;
          d.fsm       = (q.bc_cfg == 24'h0) ? ST_IDLE : ST_DELAY;
          d.done      = (q.bc_cfg == 24'h0) ? 1'b1 : d.done;
        end
      end

      // Interburst delay, then size and launch a burst
      ST_DELAY: begin
        if (q.dly != 16'h0) begin
          d.dly = q.dly - 16'h1;
        end else begin
          len = q.dir ? 11'(SLEN_BASE << q.slen) : (q.plen ? PLEN_LONG : PLEN_SHORT);
          modv = q.dir ? (q.dst_addr[12:2] & (len - 11'h1)) : (q.src_addr[12:2] & (len - 11'h1));
          sum25 = {23'h0, q.src_addr[1:0]} + {1'b0, q.bc} + 25'h3;
          n = len - modv;
          if (sum25[24:2] < {12'h0, n}) begin
            n = sum25[12:2];
          end
          // wait for outbound room on SDRAM reads
          if (!q.dir || ob_space >= len) begin
            d.need   = n;
            d.got    = 11'h0;
            d.rd_req = 1'b1;
            if (q.dir) begin
              // whole 16-byte blocks of four beats
              // surplus head words are dropped later
              d.head    = q.src_addr[3:2];
              sum25     = {14'h0, n} + {23'h0, q.src_addr[3:2]} + 25'h3;
              d.raw     = {sum25[10:2], 2'h0};
              d.rd.addr = {q.src_addr[31:4], 4'h0};
            end else begin
              d.head    = 2'h0;
              d.raw     = n;
              d.rd.addr = {q.src_addr[31:2], 2'h0};
            end
            d.rd.len = d.raw;
            d.fsm    = ST_BURST;
          end
        end
      end

      // Receive source words, realign and write
      ST_BURST: begin
        if (src_valid) begin
          idx   = q.got;
          d.got = q.got + 11'h1;
          // only words inside the window are used
          if (idx >= {9'h0, q.head} && idx < {9'h0, q.head} + q.need && q.bc != 24'h0) begin
            cur = src_data;
            bytes = 3'h4 - {1'b0, q.src_addr[1:0]};
            if ({21'h0, bytes} > q.bc) begin
              bytes = q.bc[2:0];
            end
            d.bc       = q.bc - {21'h0, bytes};
            d.src_addr = q.src_addr + {29'h0, bytes};
            d.prev     = cur;
            d.first_src = 1'b0;
            emit = !(q.skip && q.first_src) && q.dwr != 24'h0;
          end
          // full inbound FIFO or latency timer ends PCI read
          if (!q.dir && (ib_full || mlt_expired)) begin
            d.stop = 1'b1;
            endb   = 1'b1;
          end
          endb = endb || src_end || (d.got == q.raw);
        end else if (!q.dir && (ib_full || mlt_expired)) begin
          d.stop = 1'b1;
          endb   = 1'b1;
        end else if (src_end) begin
          endb = 1'b1;
        end
      end

      // Drain the last partial word
      ST_FLUSH: begin
        emit = q.dwr != 24'h0;
        cur  = ZERO32;
        d.fsm = ST_IDLE;
        d.done = 1'b1;
      end

      default: d.fsm = ST_IDLE;
    endcase

    // Write generation
    if (emit) begin
      // left rotation by sh across two words
      // bytes packed into one whole Dword
      win = {cur, q.prev} >> {(3'h4 - {1'b0, q.sh}), 3'h0};
      d.wr.data = win[31:0];
      d.wr.addr = {q.dst_addr[31:2], 2'h0};
      d.dwr     = q.dwr - 24'h1;
      d.wr_valid = 1'b1;
      d.first_wr = 1'b0;
      // destination moves to next Dword boundary
      d.dst_addr = {q.dst_addr[31:2] + 30'h1, 2'h0};
      if (q.dwr == 24'h1) begin
        d.wr.be = q.first_wr ? (q.fbe & q.lbe) : q.lbe;
      end else begin
        d.wr.be = q.first_wr ? q.fbe : BE_ALL;
      end
    end

    // Burst close-out
    if (endb) begin
      // received words were already written above
      if (d.bc == 24'h0) begin
        d.fsm  = (d.dwr != 24'h0) ? ST_FLUSH : ST_IDLE;
        d.done = (d.dwr == 24'h0) ? 1'b1 : d.done;
      end else begin
        // next burst waits the delay again
        d.fsm = ST_DELAY;
        d.dly = q.ibd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q         <= '0;
      q.fsm     <= ST_IDLE;
      q.ibd     <= IBD_RST;
      q.waitreq <= 1'b1;
      rd_be_q   <= BE_ALL;
    end else begin
      q       <= d;
      rd_be_q <= BE_ALL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [1:0]  h_dlo;     // Destination offset at start
  logic [3:0]  h_lmask;   // Final mask copied from d.lbe at start
  logic        h_seen;    // A write has been made
  logic [31:0] h_addr;    // Previous write address

  // Helper capture, taken from the data path at start and on each write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h_dlo   <= 2'h0;
      h_lmask <= 4'hF;
      h_seen  <= 1'b0;
      h_addr  <= 32'h0;
    end else begin
      if (q.fsm == ST_IDLE && d.fsm == ST_DELAY) begin
        h_dlo   <= d.dst_addr[1:0];
        h_lmask <= d.lbe;
        h_seen  <= 1'b0;
      end else if (q.wr_valid) begin
        h_seen <= 1'b1;
        h_addr <= q.wr.addr;
      end
    end
  end

  chk_first_be_low: assert property (wr_valid && !h_seen |-> (wr.be & ~(4'hF << h_dlo)) == 4'h0)
    else $error("first write enables a byte below the start offset");
  chk_last_be_mask: assert property (wr_valid && q.dwr == 24'h0 |-> (wr.be & ~h_lmask) == 4'h0)
    else $error("final write enables a byte past the end");
  chk_mid_be_all: assert property (wr_valid && h_seen && q.dwr != 24'h0 |-> wr.be == 4'hF)
    else $error("middle write not fully enabled");
  chk_read_be_all: assert property (rd_req |-> rd_be == 4'hF)
    else $error("read issued with a masked byte");
  chk_req_after_delay: assert property (rd_req |-> $past(q.fsm) == ST_DELAY && $past(q.dly) == 16'h0)
    else $error("read request before delay elapsed");
  chk_sdram_room: assert property (rd_req && q.dir |-> $past(ob_space) >= 11'(SLEN_BASE << q.slen))
    else $error("SDRAM read without FIFO room");
  chk_pci_len_cap: assert property (rd_req && !q.dir |-> rd.len <= (q.plen ? PLEN_LONG : PLEN_SHORT))
    else $error("PCI read longer than its length setting");
  chk_block_whole: assert property (rd_req && q.dir |-> rd.addr[3:0] == 4'h0 && rd.len[1:0] == 2'h0)
    else $error("SDRAM read not whole blocks");
  chk_stop_ends: assert property (q.fsm == ST_BURST && !q.dir && ib_full |=> burst_stop ##1 !rd_req)
    else $error("full inbound FIFO did not end the burst");
  chk_dst_step: assert property (wr_valid && h_seen |-> wr.addr == h_addr + 32'h4)
    else $error("destination did not step by one Dword");

  cov_unaligned_move: cover property (q.cls == CLS_UNAL && wr_valid ##[1:40] q.fsm == ST_IDLE);
  cov_disconnect:     cover property (q.fsm == ST_BURST && src_end ##1 q.fsm == ST_DELAY);
  cov_flush_write:    cover property (q.fsm == ST_FLUSH ##1 wr_valid);

endmodule
`default_nettype wire

// File: dcab_far_model.sv
// Far-side source model: answers each read burst with address-pattern words.
// Assumes rd stands from rd_req, and that burst_stop ends the burst early.
`timescale 1ns/100ps
`default_nettype none
module dcab_far_model
  import dcab_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        rd_req,
  input  wire dcab_rd_t    rd,
  input  wire logic        burst_stop,
  input  wire logic [3:0]  cut,
  input  wire logic        slow,
  output logic             src_valid,
  output logic      [31:0] src_data,
  output logic             src_end
);
  logic [29:0] ptr_q;  // Next Dword address
  logic [10:0] left_q; // Words still owed
  logic [3:0]  sent_q; // Words sent in this burst
  logic        gap_q;  // Idle slot in slow mode
  logic        last;   // This word ends the burst by disconnect

  // Byte at address a carries a[7:0], so any lane slip shows
  function automatic logic [31:0] pat(input logic [29:0] w);
    pat = {w[5:0], 2'h3, w[5:0], 2'h2, w[5:0], 2'h1, w[5:0], 2'h0};
  endfunction

  assign last = (cut != 4'h0) && (sent_q + 4'h1 == cut);

  ////////////////////////////////////////////////////////////////////////////
  // target disconnect on command; idle data changes every cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_valid <= 1'b0;
      src_end   <= 1'b0;
      src_data  <= 32'h0;
      ptr_q     <= 30'h0;
      left_q    <= 11'h0;
      sent_q    <= 4'h0;
      gap_q     <= 1'b0;
    end else if (rd_req) begin
      // New burst replaces whatever was left
      ptr_q     <= rd.addr[31:2];
      left_q    <= rd.len;
      sent_q    <= 4'h0;
      gap_q     <= slow;
      src_valid <= 1'b0;
      src_end   <= 1'b0;
      src_data  <= ~src_data;
    end else if (left_q != 11'h0 && !burst_stop && !gap_q) begin
      src_valid <= 1'b1;
      src_end   <= last;
      src_data  <= pat(ptr_q);
      ptr_q     <= ptr_q + 30'h1;
      left_q    <= last ? 11'h0 : left_q - 11'h1;
      sent_q    <= sent_q + 4'h1;
      gap_q     <= slow;
    end else begin
      // Released lines invert each cycle, so they hold the last word every second cycle
      src_valid <= 1'b0;
      src_end   <= 1'b0;
      src_data  <= ~src_data;
      gap_q     <= 1'b0;
      if (burst_stop) begin
        left_q <= 11'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: dcab_top_tb.sv
// Self-checking bench for the DMA align and burst engine.
// Assumes the far-side model and the register word map of the package.
`timescale 1ns/100ps
`default_nettype none
`define DCAB_CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module dcab_top_tb
  import dcab_pkg::*;
;
  localparam int ibd_cyc = 6; // Interburst delay used throughout
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest, rd_req;
  logic        src_valid, src_end, ib_full, mlt_expired, burst_stop, wr_valid, slow;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, src_data, rdv;
  logic [3:0]  rd_be, cut, fbe, lbe, pbe;
  logic [10:0] ob_space;
  dcab_rd_t    rd;
  dcab_wr_t    wr;
  logic [31:0] m_src, m_dst, m_bc; // Current move, source and destination
  logic        m_dir, m_plen;
  int          mismatches, total_checks, nwr, nbytes, nrd, nstop, gap;

  always #50 clk = ~clk;

  dcab_top dut_u (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rd_req(rd_req), .rd(rd), .rd_be(rd_be),
    .src_valid(src_valid), .src_data(src_data), .src_end(src_end), .ob_space(ob_space),
    .ib_full(ib_full), .mlt_expired(mlt_expired), .burst_stop(burst_stop),
    .wr_valid(wr_valid), .wr(wr));
  dcab_far_model far_u (.clk(clk), .nrst(nrst), .rd_req(rd_req), .rd(rd),
    .burst_stop(burst_stop), .cut(cut), .slow(slow), .src_valid(src_valid),
    .src_data(src_data), .src_end(src_end));

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: judge every write and every read request as it passes
  always @(posedge clk) begin
    gap++;
    if (wr_valid) begin
      `DCAB_CHK("wr dword", 30'(m_dst[31:2] + nwr), wr.addr[31:2])
      for (int i = 0; i < 4; i++) begin
        if (wr.be[i]) begin
          `DCAB_CHK("wr byte", 8'(m_src + {wr.addr[31:2], 2'(i)} - m_dst), wr.data[8*i +: 8])
          nbytes++;
        end
      end
      if (nwr > 1) `DCAB_CHK("mid be", 4'hF, pbe)
      if (nwr == 0) fbe = wr.be;
      lbe = wr.be;
      pbe = wr.be;
      nwr++;
    end
    if (rd_req) begin
      `DCAB_CHK("rd be", 4'hF, rd_be)
      if (nrd > 0) `DCAB_CHK("burst gap", 1'b1, gap > ibd_cyc)
      if (m_dir) begin
        `DCAB_CHK("blk addr", 4'h0, rd.addr[3:0])
        `DCAB_CHK("blk len", 2'h0, rd.len[1:0])
        `DCAB_CHK("fifo room", 1'b1, ob_space >= rd.len)
      end else begin
        `DCAB_CHK("pci span", 1'b1, ({7'h0, rd.addr[5:2] & (m_plen ? 4'hF : 4'h7)} + rd.len) <= (m_plen ? 16 : 8))
      end
      gap = 0;
      nrd++;
    end
    if (burst_stop) nstop++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One Avalon access, held until waitrequest is sampled low
  task automatic av_xfer(input logic we, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= !we;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      stop_test();
    end
  endtask

  // direction decides which side is source
  task automatic mv_start(input logic dir, input logic [31:0] pci, sdr, bc, input logic plen,
                          input logic [2:0] slen);
    m_dir  = dir;
    m_plen = plen;
    m_bc   = bc;
    m_src  = dir ? sdr : pci;
    m_dst  = dir ? pci : sdr;
    nwr    = 0;
    nbytes = 0;
    nrd    = 0;
    nstop  = 0;
    av_xfer(1'b1, REG_PCI, pci, rdv);
    av_xfer(1'b1, REG_SDR, sdr, rdv);
    av_xfer(1'b1, REG_BC, bc, rdv);
    av_xfer(1'b1, REG_CTRL, 32'h1 | (32'(dir) << CTRL_DIR) | (32'(plen) << CTRL_PLEN) | (32'(slen) << CTRL_SLEN), rdv);
  endtask

  // edge enables, class and byte total
  task automatic mv_end();
    logic [3:0] l;
    logic [1:0] cls;
    int         n;
    n   = 0;
    rdv = 32'h1;
    while (rdv[STAT_BUSY] !== 1'b0 && n < 400) begin
      av_xfer(1'b0, REG_STAT, 32'h0, rdv);
      n++;
    end
    if (rdv[STAT_BUSY] !== 1'b0) begin
      mismatches++;
      stop_test();
    end
    l   = (2'(m_dst[1:0] + m_bc[1:0]) == 2'h0) ? 4'hF : ~(4'hF << 2'(m_dst[1:0] + m_bc[1:0]));
    cls = (m_src[3:0] == m_dst[3:0]) ? CLS_FULL : (m_src[1:0] == m_dst[1:0]) ? CLS_DWORD : CLS_UNAL;
    `DCAB_CHK("status", {1'b1, cls, 1'b0}, rdv[3:0])
    `DCAB_CHK("bytes", m_bc, 32'(nbytes))
    if (32'(m_dst[1:0]) + m_bc <= 32'h4) begin
      `DCAB_CHK("one be", 4'(4'hF << m_dst[1:0]) & l, lbe)
    end else begin
      `DCAB_CHK("first be", 4'(4'hF << m_dst[1:0]), fbe)
      `DCAB_CHK("last be", l, lbe)
    end
    // Sticky done clears on a write of one
    av_xfer(1'b1, REG_STAT, 32'h8, rdv);
    av_xfer(1'b0, REG_STAT, 32'h0, rdv);
    `DCAB_CHK("done clr", 1'b0, rdv[STAT_DONE])
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_regs();
    av_xfer(1'b0, REG_IBD, 32'h0, rdv);
    `DCAB_CHK("ibd reset", {16'h0, IBD_RST}, rdv)
    av_xfer(1'b0, REG_STAT, 32'h0, rdv);
    `DCAB_CHK("stat reset", 32'h0, rdv)
    av_xfer(1'b1, 3'h7, 32'hFFFF_FFFF, rdv);
    av_xfer(1'b0, 3'h7, 32'h0, rdv);
    `DCAB_CHK("unmapped", 32'h0, rdv)
    av_xfer(1'b1, REG_IBD, 32'(ibd_cyc), rdv);
  endtask

  // Disconnects every three words plus a latency timer expiry
  task automatic s_cut();
    int n;
    n    = 0;
    cut  <= 4'h3;
    slow <= 1'b1;
    mv_start(1'b0, 32'h104, 32'h208, 32'd64, 1'b1, 3'h0);
    while (rd_req !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      stop_test();
    end
    @(posedge clk);
    mlt_expired <= 1'b1;
    @(posedge clk);
    mlt_expired <= 1'b0;
    // Next burst: a full inbound FIFO cuts it short as well
    n = 0;
    while (rd_req !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      stop_test();
    end
    @(posedge clk);
    ib_full <= 1'b1;
    @(posedge clk);
    ib_full <= 1'b0;
    mv_end();
    `DCAB_CHK("stopped", 1'b1, nstop > 1)
    cut <= 4'h0;
  endtask

  // No SDRAM read while the outbound FIFO lacks room
  task automatic s_room();
    ob_space <= 11'h000;
    mv_start(1'b1, 32'h100, 32'h200, 32'd64, 1'b0, 3'h1);
    repeat (30) @(posedge clk);
    `DCAB_CHK("no read", 0, nrd)
    ob_space <= 11'h040;
    mv_end();
  endtask

  // Unaligned PCI-to-SDRAM move over two bursts
  task automatic s_unal();
    mv_start(1'b0, 32'h101, 32'h203, 32'd37, 1'b0, 3'h0); // unaligned
    mv_end();
  endtask

  // Move that fits inside one destination Dword
  task automatic s_one();
    mv_start(1'b0, 32'h102, 32'h201, 32'd2, 1'b0, 3'h0); // single Dword
    mv_end();
  endtask

  // SDRAM-to-PCI with surplus head and tail words
  task automatic s_surplus();
    mv_start(1'b1, 32'h100, 32'h208, 32'd40, 1'b0, 3'h1); // surplus
    mv_end();
  endtask

  // Unaligned SDRAM-to-PCI with a short read length
  task automatic s_unal_out();
    mv_start(1'b1, 32'h102, 32'h205, 32'd13, 1'b0, 3'h0); // unaligned out
    mv_end();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 0; nrst = 0; avs_address = 0; avs_read = 0; avs_write = 0; avs_writedata = 0;
    ib_full = 0; mlt_expired = 0; ob_space = 11'h040; cut = 0; slow = 0;
    mismatches = 0; total_checks = 0; nwr = 0; nrd = 0; gap = 0; m_dir = 0; m_plen = 0;
    m_src = 0; m_dst = 0; m_bc = 0; pbe = 4'hF;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    s_regs();
    s_unal();
    s_one();
    s_cut();
    s_room();
    s_surplus();
    s_unal_out();
    stop_test();
  end
endmodule
`undef DCAB_CHK
`default_nettype wire
